// File: design/cdr_pkg.sv
package cdr_pkg;

  // Register addresses on the serial port (7-bit)
  localparam logic [6:0] ADDR_CAL_LOW = 7'h3B;
  localparam logic [6:0] ADDR_CTRL_ONE = 7'h3C;
  localparam logic [6:0] ADDR_CTRL_TWO = 7'h3D;
  localparam logic [6:0] ADDR_UPPER = 7'h3E;
  localparam logic [6:0] ADDR_LOWER = 7'h3F;

  // Values after power-on or soft reset
  localparam logic [7:0] RST_CAL_LOW = 8'h00;
  localparam logic [7:0] RST_CTRL_ONE = 8'h04;
  localparam logic [7:0] RST_CTRL_TWO = 8'h00;
  localparam logic [7:0] RST_UPPER = 8'hA8;
  localparam logic [7:0] RST_LOWER = 8'h98;

  // Field positions
  localparam int EN_POS = 0;
  localparam int FILT_POS = 2;
  localparam int CLK_POS = 0;
  localparam int MODE_POS = 7;

  // Filter codes and their shift amounts
  localparam logic [1:0] FILT_TC8 = 2'h0;
  localparam logic [1:0] FILT_TC16 = 2'h1;
  localparam logic [1:0] FILT_TC32 = 2'h2;
  localparam logic [1:0] FILT_ADAPT = 2'h3;
  localparam logic [2:0] SHIFT_TC8 = 3'h3;
  localparam logic [2:0] SHIFT_TC16 = 3'h4;
  localparam logic [2:0] SHIFT_TC32 = 3'h5;

  // Edge distances in bits for the adaptive filter
  localparam logic [3:0] ADAPT_MID_FROM = 4'h4;
  localparam logic [3:0] ADAPT_LONG_FROM = 4'h9;
  localparam int ADAPT_MAX_BITS = 10;

  // Serial frame
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam logic [4:0] DATA_START = 5'h08;

  // Recovery tick: one tick every (mask + 1) clock cycles per code
  localparam logic [2:0] DIV_MASK [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  localparam int COUNT_W = 12;

  typedef enum logic [2:0] {
    PORT_IDLE = 3'h1,
    PORT_SHIFT = 3'h2,
    PORT_DONE = 3'h4
  } port_state_t;

  typedef enum logic [2:0] {
    METER_OFF = 3'h1,
    METER_ARM = 3'h2,
    METER_RUN = 3'h4
  } meter_state_t;

endpackage

// File: design/cdr_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none

interface cdr_cfg_if;
  logic recovery_enable;
  logic [1:0] filter_constant_select;
  logic [1:0] clock_select;
  logic [7:0] upper_limit_value;
  logic [7:0] lower_limit_value;
  logic [7:0] bit_time_reference;

  modport regs (
    output recovery_enable, filter_constant_select, clock_select,
    output upper_limit_value, lower_limit_value, bit_time_reference
  );
  modport meter (
    input recovery_enable, filter_constant_select, clock_select,
    input upper_limit_value, lower_limit_value, bit_time_reference
  );
endinterface

`default_nettype wire

// File: design/serial_reg_port.sv
`timescale 1ns/1ps
`default_nettype none

module serial_reg_port import cdr_pkg::*; (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic csn_in,
  input wire logic sclk_in,
  input wire logic sdi_in,
  input wire logic [7:0] rd_data_in,
  output logic [6:0] addr_out,
  output logic wr_out,
  output logic [7:0] wr_data_out,
  output logic sdo_out,
  output logic sdo_en_out
);

  typedef struct packed {
    port_state_t st;
    logic sclk_prev;
    logic [4:0] cnt;
    logic [15:0] sh;
    logic sdo;
    logic wr;
  } port_t;

  port_t q;
  port_t d;
  logic rise;
  logic fall;

  assign rise = !q.sclk_prev && sclk_in;
  assign fall = q.sclk_prev && !sclk_in;

  // Bits arrive LSB first: address, mode, then data
  always_comb begin
    d = q;
    d.sclk_prev = sclk_in;
    d.wr = 1'h0;
    case (q.st)
      PORT_IDLE: begin
        d.sdo = 1'h0;
        if (!csn_in) begin
          d.st = PORT_SHIFT;
          d.cnt = 5'h00;
        end
      end
      PORT_SHIFT: begin
        if (csn_in) begin
          // Short frame: dropped without effect
          d.st = PORT_IDLE;
        end else begin
          if (rise) begin
            d.sh[q.cnt[3:0]] = sdi_in;
            d.cnt = q.cnt + 5'h01;
            if (q.cnt == FRAME_LEN - 5'h01) begin
              d.st = PORT_DONE;
            end
          end
          if (fall && q.cnt >= DATA_START) begin
            d.sdo = rd_data_in[q.cnt[2:0]];
          end
        end
      end
      PORT_DONE: begin
        // Write only lands once the frame is closed
        if (csn_in) begin
          d.st = PORT_IDLE;
          d.wr = q.sh[MODE_POS];
        end
      end
      default: begin
        d.st = PORT_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= '{st: PORT_IDLE, sclk_prev: 1'h0, cnt: 5'h00, sh: 16'h0000,
             sdo: 1'h0, wr: 1'h0};
    end else begin
      q <= d;
    end
  end

  assign addr_out = q.sh[6:0];
  assign wr_data_out = q.sh[15:8];
  assign wr_out = q.wr;
  assign sdo_out = q.sdo;
  assign sdo_en_out = !csn_in;

endmodule

`default_nettype wire

// File: design/bit_time_meter.sv
`timescale 1ns/1ps
`default_nettype none

module bit_time_meter import cdr_pkg::*; (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  cdr_cfg_if.meter cfg,
  input wire logic rxd_in,
  output logic [7:0] bit_time_out,
  output logic bit_time_valid_out
);

  typedef struct packed {
    meter_state_t st;
    logic [2:0] div;
    logic rx_prev;
    logic [COUNT_W-1:0] cnt;
    logic [15:0] acc;
    logic [7:0] bt;
    logic vld;
  } meter_t;

  meter_t q;
  meter_t d;
  logic tick;
  logic falling;
  logic [3:0] n_bits;
  logic [COUNT_W-1:0] per_bit;
  logic [7:0] smp;
  logic [2:0] shift;
  logic signed [16:0] diff;
  logic [15:0] acc_n;
  logic [7:0] raw;

  assign tick = (q.div == DIV_MASK[cfg.clock_select]);
  assign falling = q.rx_prev && !rxd_in;

  // Edge distance in whole bits, rounded against the reference
  always_comb begin
    n_bits = 4'h1;
    for (int k = 2; k <= ADAPT_MAX_BITS; k++) begin
      if ({q.cnt, 1'h0} >= 13'(cfg.bit_time_reference * (2 * k - 1))) begin
        n_bits = 4'(k);
      end
    end
  end

  assign per_bit = q.cnt / {8'h00, n_bits};
  assign smp = (per_bit > 12'h0FF) ? 8'hFF : per_bit[7:0];

  always_comb begin
    case (cfg.filter_constant_select)
      FILT_TC8: shift = SHIFT_TC8;
      FILT_TC16: shift = SHIFT_TC16;
      FILT_TC32: shift = SHIFT_TC32;
      default: begin
        if (n_bits >= ADAPT_LONG_FROM) begin
          shift = SHIFT_TC8;
        end else if (n_bits >= ADAPT_MID_FROM) begin
          shift = SHIFT_TC16;
        end else begin
          shift = SHIFT_TC32;
        end
      end
    endcase
  end

  // First-order filter in 8.8 fixed point
  assign diff = $signed({1'h0, smp, 8'h00}) - $signed({1'h0, q.acc});
  assign acc_n = 16'($signed({1'h0, q.acc}) + (diff >>> shift));
  assign raw = acc_n[15:8];

  always_comb begin
    d = q;
    d.rx_prev = rxd_in;
    d.div = tick ? 3'h0 : q.div + 3'h1;
    if (!cfg.recovery_enable) begin
      d.st = METER_OFF;
      d.div = 3'h0;
      d.cnt = '0;
      d.vld = 1'h0;
      d.acc = {cfg.bit_time_reference, 8'h00};
    end else begin
      case (q.st)
        METER_OFF: begin
          d.st = METER_ARM;
        end
        METER_ARM: begin
          if (falling) begin
            d.st = METER_RUN;
            d.cnt = '0;
          end
        end
        METER_RUN: begin
          if (falling) begin
            d.cnt = '0;
            d.acc = acc_n;
            d.vld = 1'h1;
            if (raw > cfg.upper_limit_value) begin
              d.bt = cfg.upper_limit_value;
            end else if (raw < cfg.lower_limit_value) begin
              d.bt = cfg.lower_limit_value;
            end else begin
              d.bt = raw;
            end
          end else if (tick && q.cnt != '1) begin
            // Saturates on too slow a baud rate
            d.cnt = q.cnt + 12'h001;
          end
        end
        default: begin
          d.st = METER_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= '{st: METER_OFF, div: 3'h0, rx_prev: 1'h1, cnt: 12'h000,
             acc: 16'h0000, bt: 8'h00, vld: 1'h0};
    end else begin
      q <= d;
    end
  end

  assign bit_time_out = q.bt;
  assign bit_time_valid_out = q.vld;

  adapt_short_a:
  assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    cfg.filter_constant_select == FILT_ADAPT && n_bits >= ADAPT_LONG_FROM
    |-> shift == SHIFT_TC8)
    else $error("adaptive filter picked wrong constant for long gap");

endmodule

`default_nettype wire

// File: design/selective_wake_cdr_config.sv
`timescale 1ns/1ps
`default_nettype none

module selective_wake_cdr_config import cdr_pkg::*; (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic soft_rst_in,
  input wire logic restart_in,
  input wire logic csn_in,
  input wire logic sclk_in,
  input wire logic sdi_in,
  input wire logic cal_done_in,
  input wire logic [7:0] cal_result_in,
  input wire logic [7:0] bit_time_ref_in,
  input wire logic rxd_in,
  output logic sdo_out,
  output logic sdo_en_out,
  output logic recovery_enable_out,
  output logic [1:0] clock_select_out,
  output logic [7:0] bit_time_out,
  output logic bit_time_valid_out
);

  // All checks below run on the one system clock
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (sys_rst_in);

  ////////////////////////////////////////////////////////////////////
  // Register state

  typedef struct packed {
    logic [7:0] cal_low;
    logic recovery_enable;
    logic [1:0] filter_constant_select;
    logic [1:0] clock_select;
    logic [7:0] upper_limit_value;
    logic [7:0] lower_limit_value;
  } regs_t;

  localparam regs_t REGS_RST = '{
    cal_low: RST_CAL_LOW,
    recovery_enable: RST_CTRL_ONE[EN_POS],
    filter_constant_select: RST_CTRL_ONE[FILT_POS +: 2],
    clock_select: RST_CTRL_TWO[CLK_POS +: 2],
    upper_limit_value: RST_UPPER,
    lower_limit_value: RST_LOWER
  };

  regs_t q;
  regs_t d;

  logic [6:0] port_addr;
  logic port_wr;
  logic [7:0] port_wr_data;
  logic [7:0] rd_data;

  ////////////////////////////////////////////////////////////////////
  // Serial register port

  serial_reg_port port_u (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .csn_in(csn_in),
    .sclk_in(sclk_in),
    .sdi_in(sdi_in),
    .rd_data_in(rd_data),
    .addr_out(port_addr),
    .wr_out(port_wr),
    .wr_data_out(port_wr_data),
    .sdo_out(sdo_out),
    .sdo_en_out(sdo_en_out)
  );

  ////////////////////////////////////////////////////////////////////
  // Read side

  always_comb begin
    rd_data = 8'h00;
    if (port_addr == ADDR_CAL_LOW) begin
      rd_data = q.cal_low;
    end else if (port_addr == ADDR_CTRL_ONE) begin
      // Unlisted bits stay zero
      rd_data[EN_POS] = q.recovery_enable;
      rd_data[FILT_POS +: 2] = q.filter_constant_select;
    end else if (port_addr == ADDR_CTRL_TWO) begin
      rd_data[CLK_POS +: 2] = q.clock_select;
    end else if (port_addr == ADDR_UPPER) begin
      rd_data = q.upper_limit_value;
    end else if (port_addr == ADDR_LOWER) begin
      rd_data = q.lower_limit_value;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Write side and resets

  // Soft reset beats restart, restart beats a host write
  always_comb begin
    d = q;
    if (soft_rst_in) begin
      d = REGS_RST;
    end else begin
      if (cal_done_in) begin
        d.cal_low = cal_result_in;
      end
      if (restart_in) begin
        // Limits, filter and clock select are left as they were
        d.recovery_enable = 1'h0;
      end else if (port_wr) begin
        if (port_addr == ADDR_CTRL_ONE) begin
          d.recovery_enable = port_wr_data[EN_POS];
          d.filter_constant_select = port_wr_data[FILT_POS +: 2];
        end else if (port_addr == ADDR_CTRL_TWO) begin
          d.clock_select = port_wr_data[CLK_POS +: 2];
        end else if (port_addr == ADDR_UPPER) begin
          d.upper_limit_value = port_wr_data;
        end else if (port_addr == ADDR_LOWER) begin
          d.lower_limit_value = port_wr_data;
        end
        // Calibration byte has no write path
      end
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= REGS_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Measurement

  cdr_cfg_if cfg_bus ();

  assign cfg_bus.recovery_enable = q.recovery_enable;
  assign cfg_bus.filter_constant_select = q.filter_constant_select;
  assign cfg_bus.clock_select = q.clock_select;
  assign cfg_bus.upper_limit_value = q.upper_limit_value;
  assign cfg_bus.lower_limit_value = q.lower_limit_value;
  assign cfg_bus.bit_time_reference = bit_time_ref_in;

  // Clock select only scales the tick rate; no real fast clock here
  bit_time_meter meter_u (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .cfg(cfg_bus),
    .rxd_in(rxd_in),
    .bit_time_out(bit_time_out),
    .bit_time_valid_out(bit_time_valid_out)
  );

  assign recovery_enable_out = q.recovery_enable;
  assign clock_select_out = q.clock_select;

  ////////////////////////////////////////////////////////////////////
  // Checks

  // Host writes count only when neither reset kind is active
  logic host_wr;
  assign host_wr = port_wr && !soft_rst_in && !restart_in;

  cal_read_only_a:
  assert property (
    port_wr && port_addr == ADDR_CAL_LOW && !cal_done_in && !soft_rst_in
    |=> $stable(q.cal_low))
    else $error("calibration byte changed by a host write");

  cal_soft_clear_a:
  assert property (soft_rst_in |=> q.cal_low == RST_CAL_LOW)
    else $error("calibration byte not cleared by soft reset");

  enable_write_a:
  assert property (
    host_wr && port_addr == ADDR_CTRL_ONE
    |=> recovery_enable_out == $past(port_wr_data[EN_POS]))
    else $error("recovery enable did not follow the write");

  filter_write_a:
  assert property (
    host_wr && port_addr == ADDR_CTRL_ONE
    |=> q.filter_constant_select == $past(port_wr_data[FILT_POS +: 2]))
    else $error("filter field did not follow the write");

  clock_write_a:
  assert property (
    host_wr && port_addr == ADDR_CTRL_TWO
    |=> clock_select_out == $past(port_wr_data[CLK_POS +: 2]))
    else $error("clock select did not follow the write");

  limits_reset_a:
  assert property (
    soft_rst_in
    |=> q.upper_limit_value == RST_UPPER && q.lower_limit_value == RST_LOWER)
    else $error("limit bytes wrong after soft reset");

  controls_reset_a:
  assert property (
    soft_rst_in
    |=> !recovery_enable_out && q.filter_constant_select == FILT_TC16
        && clock_select_out == RST_CTRL_TWO[CLK_POS +: 2])
    else $error("control bytes wrong after soft reset");

  restart_clear_a:
  assert property (
    restart_in && !soft_rst_in
    |=> !recovery_enable_out
        && q.filter_constant_select == $past(q.filter_constant_select)
        && q.upper_limit_value == $past(q.upper_limit_value))
    else $error("restart did not clear enable or lost settings");

  reserved_zero_a:
  assert property (
    (port_addr == ADDR_CTRL_ONE) |-> (rd_data & 8'hF2) == 8'h00)
    else $error("reserved control one bits read non-zero");

  reserved_two_a:
  assert property (
    (port_addr == ADDR_CTRL_TWO) |-> rd_data[7:2] == 6'h00)
    else $error("reserved control two bits read non-zero");

  clamp_range_a:
  assert property (
    bit_time_valid_out && $changed(bit_time_out)
    && $past(q.upper_limit_value) >= $past(q.lower_limit_value)
    && $stable(q.upper_limit_value) && $stable(q.lower_limit_value)
    |-> bit_time_out <= q.upper_limit_value
        && bit_time_out >= q.lower_limit_value)
    else $error("recovered bit time outside the limits");

  off_no_value_a:
  assert property (!recovery_enable_out |=> !bit_time_valid_out)
    else $error("measurement valid while recovery is off");

  cal_load_a:
  assert property (
    cal_done_in && !soft_rst_in |=> q.cal_low == $past(cal_result_in))
    else $error("calibration byte did not load the result");

  cal_read_back_a:
  assert property (
    (port_addr == ADDR_CAL_LOW) |-> rd_data == q.cal_low)
    else $error("calibration byte read back wrong");

  upper_write_a:
  assert property (
    host_wr && port_addr == ADDR_UPPER
    |=> q.upper_limit_value == $past(port_wr_data))
    else $error("upper limit did not follow the write");

  limit_read_back_a:
  assert property (
    (port_addr == ADDR_UPPER) |-> rd_data == q.upper_limit_value)
    else $error("upper limit read back wrong");

  lower_write_a:
  assert property (
    host_wr && port_addr == ADDR_LOWER
    |=> q.lower_limit_value == $past(port_wr_data))
    else $error("lower limit did not follow the write");

  restart_keeps_a:
  assert property (
    restart_in && !soft_rst_in
    |=> clock_select_out == $past(clock_select_out)
        && q.lower_limit_value == $past(q.lower_limit_value))
    else $error("restart changed clock select or lower limit");

  valid_needs_enable_a:
  assert property ($rose(bit_time_valid_out) |-> $past(recovery_enable_out))
    else $error("measurement became valid while recovery was off");

  ctrl_write_c: cover property (host_wr && port_addr == ADDR_CTRL_ONE);
  restart_c: cover property (restart_in && recovery_enable_out);
  adapt_value_c: cover property (
    q.filter_constant_select == FILT_ADAPT && $rose(bit_time_valid_out));
  clamp_high_c: cover property (
    bit_time_valid_out && bit_time_out == q.upper_limit_value);
  clamp_low_c: cover property (
    bit_time_valid_out && bit_time_out == q.lower_limit_value);

endmodule

`default_nettype wire

// File: tb/can_node_model.sv
`timescale 1ns/1ps
`default_nettype none

// Wake-frame sender on the received line; recessive high between edges
module can_node_model (
  input wire logic mclk_in,
  output logic rxd_out
);
  initial rxd_out = 1'b1;

  // Falling edges exactly per_clk apart; short dominant part keeps spacing exact
  task automatic send_edges(input int n_edges, input int per_clk);
    for (int i = 0; i < n_edges; i++) begin
      rxd_out <= 1'b0;
      repeat (8) @(posedge mclk_in);
      rxd_out <= 1'b1;
      if (i < n_edges - 1) repeat (per_clk - 8) @(posedge mclk_in);
    end
  endtask
endmodule

`default_nettype wire

// File: tb/selective_wake_cdr_config_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module selective_wake_cdr_config_tb_top import cdr_pkg::*;;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic soft_rst = 1'b0;
  logic restart = 1'b0;
  logic csn = 1'b1;
  logic sclk = 1'b0;
  logic sdi = 1'b0;
  logic cal_done = 1'b0;
  logic [7:0] cal_result = 8'h00;
  logic [7:0] bit_ref = 8'hA0;
  logic rxd;
  logic sdo, sdo_en, rec_en, bt_valid;
  logic [1:0] clk_sel;
  logic [7:0] bt;
  int n_mismatch = 0;
  int n_tests = 0;

  always #25 mclk_in = ~mclk_in;

  selective_wake_cdr_config DUT (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .soft_rst_in(soft_rst),
    .restart_in(restart),
    .csn_in(csn),
    .sclk_in(sclk),
    .sdi_in(sdi),
    .cal_done_in(cal_done),
    .cal_result_in(cal_result),
    .bit_time_ref_in(bit_ref),
    .rxd_in(rxd),
    .sdo_out(sdo),
    .sdo_en_out(sdo_en),
    .recovery_enable_out(rec_en),
    .clock_select_out(clk_sel),
    .bit_time_out(bt),
    .bit_time_valid_out(bt_valid)
  );

  can_node_model node (
    .mclk_in(mclk_in),
    .rxd_out(rxd)
  );

  ////////////////////////////////////////
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // sclk stays high 4 mclk cycles and low 8; the high phase is four times the one-cycle minimum the port needs
  task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] wd,
      output logic [7:0] rd);
    logic [15:0] f;
    f = {wd, w, a};
    rd = 8'h00;
    csn <= 1'b0;
    for (int k = 0; k < 16; k++) begin
      repeat (4) @(posedge mclk_in);
      sdi <= f[k];
      repeat (4) @(posedge mclk_in);
      sclk <= 1'b1;
      if (k >= 8) rd[k - 8] = sdo;
      if (k == 15) check8({7'h00, sdo_en}, 8'h01, "driver on in frame");
      repeat (4) @(posedge mclk_in);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge mclk_in);
    csn <= 1'b1;
    repeat (4) @(posedge mclk_in);
  endtask

  // Reads carry non-zero data so a read that writes shows up
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    xfer(a, 1'b0, 8'hA5, d);
    check8(d, exp, what);
  endtask

  task automatic measure(input logic [1:0] filt, input logic [1:0] code, input int ticks,
      input int n_edges, input logic [7:0] exp, input string what);
    logic [7:0] d;
    xfer(ADDR_CTRL_TWO, 1'b1, {6'h00, code}, d);
    xfer(ADDR_CTRL_ONE, 1'b1, {4'h0, filt, 2'h0}, d);
    xfer(ADDR_CTRL_ONE, 1'b1, {4'h0, filt, 2'h1}, d);
    // Gaps keep the tick counter far from saturation yet well resolved
    node.send_edges(n_edges, ticks << code);
    repeat (10) @(posedge mclk_in);
    check8({7'h00, bt_valid}, 8'h01, what);
    check8(bt, exp, what);
  endtask

  ////////////////////////////////////////
  task automatic check_defaults();
    logic [6:0] a [6] = '{ADDR_CAL_LOW, ADDR_CTRL_ONE, ADDR_CTRL_TWO, ADDR_UPPER,
        ADDR_LOWER, 7'h40};
    logic [7:0] e [6] = '{RST_CAL_LOW, RST_CTRL_ONE, RST_CTRL_TWO, RST_UPPER,
        RST_LOWER, 8'h00};
    for (int i = 0; i < 6; i++) rd_chk(a[i], e[i], "reset value");
    check8({7'h00, rec_en}, 8'h00, "enable after reset");
    check8({7'h00, sdo_en}, 8'h00, "driver off when idle");
  endtask

  task automatic t_write_fields();
    logic [6:0] a [5] = '{ADDR_CAL_LOW, ADDR_CTRL_ONE, ADDR_CTRL_TWO, ADDR_UPPER, ADDR_LOWER};
    logic [7:0] e [5] = '{8'h00, 8'h0D, 8'h03, 8'hFF, 8'hFF};
    logic [7:0] d;
    for (int i = 0; i < 5; i++) xfer(a[i], 1'b1, 8'hFF, d);
    for (int i = 0; i < 5; i++) rd_chk(a[i], e[i], "all ones");
    check8({7'h00, rec_en}, 8'h01, "enable on");
    for (int c = 0; c < 4; c++) begin
      xfer(ADDR_CTRL_TWO, 1'b1, {6'h00, c[1:0]}, d);
      check8({6'h00, clk_sel}, {6'h00, c[1:0]}, "clock select");
    end
    for (int f = 0; f < 4; f++) begin
      xfer(ADDR_CTRL_ONE, 1'b1, {4'h0, f[1:0], 2'h0}, d);
      check8({7'h00, rec_en}, 8'h00, "enable off");
      xfer(ADDR_CTRL_ONE, 1'b1, {4'h0, f[1:0], 2'h1}, d);
      rd_chk(ADDR_CTRL_ONE, {4'h0, f[1:0], 2'h1}, "filter code");
    end
  endtask

  task automatic t_restart();
    cal_result <= 8'h5A;
    cal_done <= 1'b1;
    @(posedge mclk_in);
    cal_done <= 1'b0;
    restart <= 1'b1;
    @(posedge mclk_in);
    restart <= 1'b0;
    repeat (2) @(posedge mclk_in);
    check8({7'h00, rec_en}, 8'h00, "restart enable");
    rd_chk(ADDR_CTRL_ONE, 8'h0C, "restart control one");
    rd_chk(ADDR_UPPER, 8'hFF, "restart upper");
    rd_chk(ADDR_CAL_LOW, 8'h5A, "calibration");
    soft_rst <= 1'b1;
    @(posedge mclk_in);
    soft_rst <= 1'b0;
    repeat (2) @(posedge mclk_in);
    check_defaults();
  endtask

  // Step of 36 ticks from a reference of 160 lands mid-integer per constant
  task automatic t_filter();
    logic [7:0] e [3] = '{8'hA4, 8'hA2, 8'hA1};
    logic [7:0] d;
    xfer(ADDR_UPPER, 1'b1, 8'hFF, d);
    xfer(ADDR_LOWER, 1'b1, 8'h00, d);
    for (int c = 0; c < 3; c++) measure(c[1:0], c[1:0], 196, 2, e[c], "fixed filter");
  endtask

  // Edge spacings of 9, 4 and 3 bits, each counted with a margin for tick jitter
  task automatic t_adaptive();
    measure(2'h3, 2'h0, 1516, 2, 8'hA1, "adaptive nine bits");
    measure(2'h3, 2'h0, 706, 2, 8'hA1, "adaptive four bits");
    measure(2'h3, 2'h0, 529, 2, 8'hA0, "adaptive three bits");
  endtask

  task automatic t_clamp();
    logic [7:0] d;
    xfer(ADDR_UPPER, 1'b1, 8'hA8, d);
    xfer(ADDR_LOWER, 1'b1, 8'h98, d);
    measure(2'h0, 2'h0, 220, 30, 8'hA8, "upper clamp");
    measure(2'h0, 2'h0, 110, 30, 8'h98, "lower clamp");
    xfer(ADDR_CTRL_ONE, 1'b1, 8'h00, d);
    check8({7'h00, bt_valid}, 8'h00, "valid after disable");
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    check_defaults();
    t_write_fields();
    t_restart();
    t_filter();
    t_adaptive();
    t_clamp();
    give_verdict();
  end

  // Roughly three times the expected run
  initial begin
    #4200000;
    n_mismatch++;
    $display("Error at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule

`default_nettype wire
